/* rtl/tmr_pkg.sv */
// timer compare/interrupt package: register map, fields, carriers
// Overview of operation
// - pwm b enable clears counter after top
// - normal mode b match: off, toggle, clear, set
// - inverted b output unconnected in normal mode
// - force b applies output action, no interrupt
// - force b uses mode written same cycle
// - force b reads zero, ignored in pwm
// - force a applies action, ignored in pwm
// - force a always reads zero
// - prescaler reset pulses, self clears, reads zero
// - counter write lands one cycle later
// - match only when counter counts up
// - software counter write never causes match
// - a/b match sets flag after delay
// - clear on top match clears counter
// - compare a interrupt gated by enables
// - compare b interrupt gated by enables
// - overflow sets flag, gated interrupt request
// - flag a cleared by vector or write-one
// - flag b cleared by vector or write-one
// - normal overflow only on wrap, not clear
package tmr_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_COUNTER = 8'h10;
  localparam logic [7:0] ADDR_CMP_A = 8'h14;
  localparam logic [7:0] ADDR_CMP_B = 8'h18;
  localparam logic [7:0] ADDR_CMP_TOP = 8'h1c;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h38;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int GC_SYNC_HALT = 7;
  localparam int GC_PWM_B = 6;
  localparam int GC_MODE_B_HI = 5;
  localparam int GC_MODE_B_LO = 4;
  localparam int GC_FORCE_B = 3;
  localparam int GC_FORCE_A = 2;
  localparam int GC_PSR_FAST = 1;
  localparam int MC_CLEAR_TOP = 7;
  localparam int MC_PWM_A = 6;
  localparam int MC_MODE_A_HI = 5;
  localparam int MC_MODE_A_LO = 4;
  localparam int IM_CMP_A = 6;
  localparam int IM_CMP_B = 5;
  localparam int IM_OTHER_A = 4;
  localparam int IM_OTHER_B = 3;
  localparam int IM_OVF = 2;
  localparam int IF_CMP_A = 6;
  localparam int IF_CMP_B = 5;
  localparam int IF_OVF = 2;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_SET = 2'h3;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic val;
    logic oe;
    logic inv_val;
    logic inv_oe;
  } tmr_pin_s;

  typedef struct packed {
    logic req_a;
    logic req_b;
    logic req_ovf;
  } tmr_irq_s;

endpackage

/* rtl/tmr_compare_unit.sv */
// timer counter with compare, force, flag and apb register logic
//
// The implementer's own choice: the APB slave port.
module tmr_compare_unit (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic timer_tick,
  input wire logic global_irq_enable,
  input wire tmr_pkg::tmr_irq_s vector_ack,
  output tmr_pkg::tmr_irq_s irq_req,
  output logic prescaler_reset_fast,
  // compare pins
  output tmr_pkg::tmr_pin_s compare_a_output,
  output tmr_pkg::tmr_pin_s compare_b_output
);

  typedef struct packed {
    logic clear_on_top_match;
    logic pwm_a_enable;
    logic [1:0] mode_a;
    logic [3:0] clk_sel;
    logic sync_halt_mode;
    logic pwm_b_enable;
    logic [1:0] mode_b;
    logic [4:0] irq_en;
    logic flag_a;
    logic flag_b;
    logic flag_ovf;
    logic clr_a;
    logic clr_b;
    logic clr_ovf;
    logic ev_a;
    logic ev_b;
    logic ev_ovf;
    logic [7:0] cnt;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] cmp_top;
    logic [7:0] wr_val;
    logic wr_pend;
    logic frc_a;
    logic frc_b;
    logic [1:0] frc_mode_a;
    logic [1:0] frc_mode_b;
    tmr_pkg::tmr_pin_s pin_a;
    tmr_pkg::tmr_pin_s pin_b;
    logic psr;
    tmr_pkg::tmr_irq_s irq;
    logic [7:0] rdata;
    logic ready;
    logic slverr;
    logic rd_gen;
  } tmr_state_s;

  tmr_state_s s_q;
  tmr_state_s s_d;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic out_action(input logic [1:0] mode, input logic cur);
    case (mode)
      tmr_pkg::MODE_TOGGLE: out_action = ~cur;
      tmr_pkg::MODE_CLEAR: out_action = 1'b0;
      tmr_pkg::MODE_SET: out_action = 1'b1;
      default: out_action = cur;
    endcase
  endfunction

  // next pin state of one channel
  function automatic tmr_pkg::tmr_pin_s pin_next(input logic pwm, input logic [1:0] mode,
      input logic match, input logic at_one, input logic frc, input logic [1:0] frc_mode,
      input tmr_pkg::tmr_pin_s cur);
    tmr_pkg::tmr_pin_s p;
    p = cur;
    if (pwm) begin
      p.oe = (mode != tmr_pkg::MODE_OFF);
      if (match) begin
        p.val = (mode == tmr_pkg::MODE_SET);
      end else if (at_one) begin
        p.val = (mode != tmr_pkg::MODE_SET);
      end
      p.inv_oe = (mode == tmr_pkg::MODE_TOGGLE);
      p.inv_val = ~p.val;
    end else begin
      p.oe = (mode != tmr_pkg::MODE_OFF);
      if (frc) begin
        p.val = out_action(frc_mode, cur.val);
      end else if (match) begin
        p.val = out_action(mode, cur.val);
      end
      p.inv_oe = 1'b0;
      p.inv_val = 1'b0;
    end
    return p;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input tmr_state_s s);
    case (addr)
      tmr_pkg::ADDR_COUNTER: read_mux = s.cnt;
      tmr_pkg::ADDR_CMP_A: read_mux = s.cmp_a;
      tmr_pkg::ADDR_CMP_B: read_mux = s.cmp_b;
      tmr_pkg::ADDR_CMP_TOP: read_mux = s.cmp_top;
      tmr_pkg::ADDR_GEN_CTRL: read_mux = {s.sync_halt_mode, s.pwm_b_enable, s.mode_b, 4'h0};
      tmr_pkg::ADDR_MAIN_CTRL: read_mux = {s.clear_on_top_match, s.pwm_a_enable, s.mode_a,
          s.clk_sel};
      tmr_pkg::ADDR_IRQ_MASK: read_mux = {1'b0, s.irq_en, 2'h0};
      tmr_pkg::ADDR_IRQ_FLAGS: read_mux = {1'b0, s.flag_a, s.flag_b, 2'h0, s.flag_ovf, 2'h0};
      default: read_mux = tmr_pkg::RST_REG;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    case (addr)
      tmr_pkg::ADDR_COUNTER, tmr_pkg::ADDR_CMP_A, tmr_pkg::ADDR_CMP_B,
      tmr_pkg::ADDR_CMP_TOP, tmr_pkg::ADDR_GEN_CTRL, tmr_pkg::ADDR_MAIN_CTRL,
      tmr_pkg::ADDR_IRQ_MASK, tmr_pkg::ADDR_IRQ_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // decode and counter terms
  // ----------------------------------------
  logic wr_en;
  logic wr_ok;
  logic wr_cnt;
  logic wr_gen;
  logic wr_flags;
  logic step;
  logic top_clr;
  logic any_pwm;
  logic [7:0] cnt_nxt;
  logic match_a;
  logic match_b;
  logic at_one;
  logic ovf;

  assign wr_en = psel && penable && pwrite && s_q.ready;
  assign wr_ok = wr_en && mapped(paddr);
  assign wr_cnt = wr_en && (paddr == tmr_pkg::ADDR_COUNTER);
  assign wr_gen = wr_en && (paddr == tmr_pkg::ADDR_GEN_CTRL);
  assign wr_flags = wr_en && (paddr == tmr_pkg::ADDR_IRQ_FLAGS);
  assign any_pwm = s_q.pwm_a_enable || s_q.pwm_b_enable;
  // counting stalls while a software write is pending, so the write wins
  assign step = timer_tick && (s_q.clk_sel != 4'h0) && !s_q.wr_pend;
  assign top_clr = (s_q.cnt == s_q.cmp_top) && (s_q.clear_on_top_match || any_pwm);
  assign cnt_nxt = top_clr ? tmr_pkg::CNT_ZERO : s_q.cnt + 8'h01;
  assign match_a = step && (cnt_nxt == s_q.cmp_a);
  assign match_b = step && (cnt_nxt == s_q.cmp_b);
  assign at_one = step && (cnt_nxt == tmr_pkg::CNT_ONE);
  // pwm: wrap at top; normal: only the ff to 00 wrap
  assign ovf = step && (any_pwm ? top_clr : (s_q.cnt == tmr_pkg::CNT_MAX && !top_clr));

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // apb: zero-wait, answer prepared in the setup cycle
    s_d.ready = psel && !penable;
    s_d.slverr = psel && !penable && !mapped(paddr);
    s_d.rdata = read_mux(paddr, s_q);
    s_d.rd_gen = psel && !penable && !pwrite && (paddr == tmr_pkg::ADDR_GEN_CTRL);

    // counter and pending software write
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      s_d.cnt = s_q.wr_val;
    end else if (step) begin
      s_d.cnt = cnt_nxt;
    end
    if (wr_cnt) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_val = pwdata[7:0];
    end

    // match events, one stage of delay before the flags
    s_d.ev_a = match_a;
    s_d.ev_b = match_b;
    s_d.ev_ovf = ovf;

    // pins
    s_d.pin_a = pin_next(s_q.pwm_a_enable, s_q.mode_a, match_a, at_one, s_q.frc_a,
        s_q.frc_mode_a, s_q.pin_a);
    s_d.pin_b = pin_next(s_q.pwm_b_enable, s_q.mode_b, match_b, at_one, s_q.frc_b,
        s_q.frc_mode_b, s_q.pin_b);
    s_d.frc_a = 1'b0;
    s_d.frc_b = 1'b0;
    s_d.psr = 1'b0;

    // flags: set wins over any clear
    s_d.flag_a = s_q.ev_a || (s_q.flag_a && !s_q.clr_a && !vector_ack.req_a);
    s_d.flag_b = s_q.ev_b || (s_q.flag_b && !s_q.clr_b && !vector_ack.req_b);
    s_d.flag_ovf = s_q.ev_ovf || (s_q.flag_ovf && !s_q.clr_ovf && !vector_ack.req_ovf);
    s_d.clr_a = wr_flags && pwdata[tmr_pkg::IF_CMP_A];
    s_d.clr_b = wr_flags && pwdata[tmr_pkg::IF_CMP_B];
    s_d.clr_ovf = wr_flags && pwdata[tmr_pkg::IF_OVF];

    // interrupt requests
    s_d.irq.req_a = s_q.flag_a && s_q.irq_en[tmr_pkg::IM_CMP_A - 2] && global_irq_enable;
    s_d.irq.req_b = s_q.flag_b && s_q.irq_en[tmr_pkg::IM_CMP_B - 2] && global_irq_enable;
    s_d.irq.req_ovf = s_q.flag_ovf && s_q.irq_en[tmr_pkg::IM_OVF - 2] && global_irq_enable;

    // register writes
    if (wr_ok) begin
      case (paddr)
        tmr_pkg::ADDR_CMP_A: s_d.cmp_a = pwdata[7:0];
        tmr_pkg::ADDR_CMP_B: s_d.cmp_b = pwdata[7:0];
        tmr_pkg::ADDR_CMP_TOP: s_d.cmp_top = pwdata[7:0];
        tmr_pkg::ADDR_MAIN_CTRL: begin
          s_d.clear_on_top_match = pwdata[tmr_pkg::MC_CLEAR_TOP];
          s_d.pwm_a_enable = pwdata[tmr_pkg::MC_PWM_A];
          s_d.mode_a = pwdata[tmr_pkg::MC_MODE_A_HI:tmr_pkg::MC_MODE_A_LO];
          s_d.clk_sel = pwdata[3:0];
        end
        tmr_pkg::ADDR_GEN_CTRL: begin
          s_d.sync_halt_mode = pwdata[tmr_pkg::GC_SYNC_HALT];
          s_d.pwm_b_enable = pwdata[tmr_pkg::GC_PWM_B];
          s_d.mode_b = pwdata[tmr_pkg::GC_MODE_B_HI:tmr_pkg::GC_MODE_B_LO];
          // forces are staged and applied next cycle; force bits are not stored
          s_d.frc_b = pwdata[tmr_pkg::GC_FORCE_B] && !pwdata[tmr_pkg::GC_PWM_B];
          s_d.frc_mode_b = pwdata[tmr_pkg::GC_MODE_B_HI:tmr_pkg::GC_MODE_B_LO];
          s_d.frc_a = pwdata[tmr_pkg::GC_FORCE_A] && !s_q.pwm_a_enable;
          s_d.frc_mode_a = s_q.mode_a;
          s_d.psr = pwdata[tmr_pkg::GC_PSR_FAST];
        end
        tmr_pkg::ADDR_IRQ_MASK: s_d.irq_en = pwdata[6:2];
        default: s_d.wr_val = s_d.wr_val;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata = {24'h000000, s_q.rdata};
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign irq_req = s_q.irq;
  assign prescaler_reset_fast = s_q.psr;
  assign compare_a_output = s_q.pin_a;
  assign compare_b_output = s_q.pin_b;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_pwm_top_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && step && s_q.pwm_b_enable && s_q.cnt == s_q.cmp_top)
      |=> (s_q.cnt == tmr_pkg::CNT_ZERO);
  endproperty
  a_pwm_top_clear: assert property (p_pwm_top_clear) else $error("pwm top clear missed");

  property p_toggle_b;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && match_b && !s_q.frc_b && !s_q.pwm_b_enable
       && s_q.mode_b == tmr_pkg::MODE_TOGGLE)
      |=> (s_q.pin_b.val != $past(s_q.pin_b.val));
  endproperty
  a_toggle_b: assert property (p_toggle_b) else $error("b toggle missed");

  property p_inv_b_off;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && !s_q.pwm_b_enable && !wr_gen) ##1 clk_en |=> !s_q.pin_b.inv_oe;
  endproperty
  a_inv_b_off: assert property (p_inv_b_off) else $error("inverted b driven");

  property p_force_b;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_gen && pwdata[tmr_pkg::GC_FORCE_B] && !pwdata[tmr_pkg::GC_PWM_B]
       && pwdata[tmr_pkg::GC_MODE_B_HI:tmr_pkg::GC_MODE_B_LO] == tmr_pkg::MODE_SET)
      ##1 clk_en |=> s_q.pin_b.val;
  endproperty
  a_force_b: assert property (p_force_b) else $error("forced set on b missed");

  property p_force_pwm_ignored;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_gen && pwdata[tmr_pkg::GC_PWM_B]) |=> !s_q.frc_b;
  endproperty
  a_force_pwm_ignored: assert property (p_force_pwm_ignored) else $error("force in pwm");

  property p_gen_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      s_q.rd_gen |-> (prdata[3:1] == 3'h0);
  endproperty
  a_gen_reads_zero: assert property (p_gen_reads_zero) else $error("force bit read one");

  property p_psr_pulse;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_gen && pwdata[tmr_pkg::GC_PSR_FAST]) ##1 clk_en
      |-> prescaler_reset_fast ##1 !prescaler_reset_fast;
  endproperty
  a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset not a pulse");

  property p_cnt_write;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_cnt) ##1 clk_en |=> (s_q.cnt == $past(pwdata[7:0], 2));
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

  property p_flag_a_set;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && match_a) ##1 clk_en |=> s_q.flag_a;
  endproperty
  a_flag_a_set: assert property (p_flag_a_set) else $error("flag a not set");

  property p_ctc_no_ovf;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && step && !any_pwm && top_clr && s_q.cnt != tmr_pkg::CNT_MAX) |=> !s_q.ev_ovf;
  endproperty
  a_ctc_no_ovf: assert property (p_ctc_no_ovf) else $error("overflow on clear");

  property p_irq_a;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.flag_a && s_q.irq_en[tmr_pkg::IM_CMP_A - 2] && global_irq_enable)
      |=> irq_req.req_a;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a not raised");

  property p_irq_b;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.flag_b && s_q.irq_en[tmr_pkg::IM_CMP_B - 2] && global_irq_enable)
      |=> irq_req.req_b;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b not raised");

  property p_flag_b_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_flags && pwdata[tmr_pkg::IF_CMP_B] && !match_b && !s_q.ev_b)
      ##1 (clk_en && !match_b) |=> !s_q.flag_b;
  endproperty
  a_flag_b_clear: assert property (p_flag_b_clear) else $error("flag b not cleared");

  property p_flag_a_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_flags && pwdata[tmr_pkg::IF_CMP_A] && !match_a && !s_q.ev_a)
      ##1 (clk_en && !match_a) |=> !s_q.flag_a;
  endproperty
  a_flag_a_clear: assert property (p_flag_a_clear) else $error("flag a not cleared");

endmodule

/* test/tmr_pin_model.sv */
// port pin model: pad levels behind the compare outputs
module tmr_pin_model (
  // compare unit side
  input wire tmr_pkg::tmr_pin_s pin_a,
  input wire tmr_pkg::tmr_pin_s pin_b,
  // port side
  input wire logic dir_out,
  output logic pad_a,
  output logic pad_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // pad follows the unit only with direction set and oe high, pull-up otherwise
  assign pad_a = (dir_out && pin_a.oe) ? pin_a.val : 1'b1;
  assign pad_b = (dir_out && pin_b.oe) ? pin_b.val : 1'b1;
endmodule

/* test/tmr_compare_unit_bench.sv */
// self-checking bench for the timer compare unit
module tmr_compare_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_tick, glb, psr, dir, rd_e;
  logic en;
  logic [7:0] paddr, rd_v;
  logic [31:0] pwdata, prdata;
  logic pad_a, pad_b;
  tmr_pkg::tmr_irq_s ack, irq;
  tmr_pkg::tmr_pin_s pa, pb;
  int bad_count, checks, psr_seen, m_cnt, m_ra, m_rb, m_top;
  bit m_fa, m_fb, m_fo, m_ctc, m_pwm, m_pb, v;
  logic [1:0] modes [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
  logic [7:0] addrs [8] = '{tmr_pkg::ADDR_COUNTER, tmr_pkg::ADDR_CMP_A, tmr_pkg::ADDR_CMP_B,
    tmr_pkg::ADDR_CMP_TOP, tmr_pkg::ADDR_GEN_CTRL, tmr_pkg::ADDR_MAIN_CTRL,
    tmr_pkg::ADDR_IRQ_MASK, tmr_pkg::ADDR_IRQ_FLAGS};

  tmr_compare_unit tmr_compare_unit_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .global_irq_enable(glb), .vector_ack(ack), .irq_req(irq),
    .prescaler_reset_fast(psr), .compare_a_output(pa), .compare_b_output(pb));

  tmr_pin_model tmr_pin_model_inst (
    .pin_a(pa), .pin_b(pb), .dir_out(dir), .pad_a(pad_a), .pad_b(pad_b));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (psr === 1'b1) psr_seen++;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 8'h01, {7'h0, pready});
    rd_v = prdata[7:0];
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("reg", e, rd_v);
  endtask

  // one counter tick of the reference model
  task step;
    if ((m_ctc || m_pwm) && m_cnt == m_top) begin
      m_cnt = 0;
      m_fo |= m_pwm;
    end else begin
      m_fo |= (m_cnt == 255);
      m_cnt = (m_cnt + 1) % 256;
    end
    m_fa |= (m_cnt == m_ra);
    m_fb |= (m_cnt == m_rb);
    if (!m_pwm && m_cnt == m_rb) m_pb = !m_pb;
  endtask

  task run(input int n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) begin
      @(posedge pclk);
      step();
    end
    timer_tick <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task state;
    rd(tmr_pkg::ADDR_COUNTER, m_cnt[7:0]);
    rd(tmr_pkg::ADDR_IRQ_FLAGS, {1'b0, m_fa, m_fb, 2'b0, m_fo, 2'b0});
    chk("irq", {5'h0, m_fa & glb, m_fb & glb, m_fo & glb}, {5'h0, irq});
    if (!m_pwm) chk("pin_b", {7'h0, m_pb}, {7'h0, pb.val});
  endtask

  task pulse_ack(input tmr_pkg::tmr_irq_s a);
    @(posedge pclk);
    ack <= a;
    @(posedge pclk);
    ack <= '0;
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, timer_tick, glb, dir, presetn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack = '0;
    en = 1'b1;
    void'($urandom(32'h3ad040c0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h00, 8'h00);
    chk("slverr", 8'h01, {7'h0, rd_e});
    wr(tmr_pkg::ADDR_IRQ_MASK, 8'hff);
    rd(tmr_pkg::ADDR_IRQ_MASK, 8'h7c);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'hff);
    rd(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    dir <= 1'b1;
    foreach (modes[i]) begin
      wr(tmr_pkg::ADDR_GEN_CTRL, {2'b0, modes[i], 4'h8});
      if (modes[i] != 2'h0) m_pb = (modes[i] == 2'h1) ? !m_pb : modes[i][0];
      repeat (3) @(posedge pclk);
      chk("pin_b", {7'h0, m_pb}, {7'h0, pb.val});
      chk("oe_b", {7'h0, modes[i] != 2'h0}, {7'h0, pb.oe});
      chk("inv_oe_b", 8'h00, {7'h0, pb.inv_oe});
      chk("pad_b", {7'h0, modes[i] != 2'h0 ? m_pb : 1'b1}, {7'h0, pad_b});
    end
    rd(tmr_pkg::ADDR_GEN_CTRL, 8'h10);
    rd(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(tmr_pkg::ADDR_MAIN_CTRL, 8'h30);
    wr(tmr_pkg::ADDR_GEN_CTRL, 8'h14);
    repeat (3) @(posedge pclk);
    chk("pin_a", 8'h01, {7'h0, pa.val});
    chk("oe_a", 8'h01, {7'h0, pa.oe});
    chk("pad_a", 8'h01, {7'h0, pad_a});
    rd(tmr_pkg::ADDR_GEN_CTRL, 8'h10);
    wr(tmr_pkg::ADDR_GEN_CTRL, 8'h12);
    wr(tmr_pkg::ADDR_GEN_CTRL, 8'h10);
    repeat (3) @(posedge pclk);
    rd(tmr_pkg::ADDR_GEN_CTRL, 8'h10);
    chk("psr_pulses", 8'h01, psr_seen[7:0]);
    m_ra = 32 + $urandom % 16;
    m_rb = m_ra + 16 + $urandom % 16;
    wr(tmr_pkg::ADDR_CMP_A, m_ra[7:0]);
    wr(tmr_pkg::ADDR_CMP_B, m_rb[7:0]);
    wr(tmr_pkg::ADDR_IRQ_MASK, 8'h64);
    glb <= 1'b1;
    wr(tmr_pkg::ADDR_COUNTER, m_ra[7:0]);
    m_cnt = m_ra;
    repeat (3) @(posedge pclk);
    state();
    wr(tmr_pkg::ADDR_MAIN_CTRL, 8'h01);
    run(m_rb - m_ra + 2);
    state();
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    state();
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h20);
    m_fb = 1'b0;
    state();
    wr(tmr_pkg::ADDR_COUNTER, 8'hfe);
    m_cnt = 254;
    run(3);
    state();
    pulse_ack(3'b001);
    m_fo = 1'b0;
    state();
    wr(tmr_pkg::ADDR_COUNTER, m_ra[7:0] - 8'h02);
    m_cnt = m_ra - 2;
    run(2);
    state();
    glb <= 1'b0;
    repeat (3) @(posedge pclk);
    state();
    glb <= 1'b1;
    pulse_ack(3'b100);
    m_fa = 1'b0;
    state();
    wr(tmr_pkg::ADDR_COUNTER, m_ra[7:0] - 8'h01);
    m_cnt = m_ra - 1;
    run(1);
    state();
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h40);
    m_fa = 1'b0;
    state();
    // clock enable low: ticks must not move the counter
    en <= 1'b0;
    timer_tick <= 1'b1;
    repeat (5) @(posedge pclk);
    timer_tick <= 1'b0;
    en <= 1'b1;
    state();
    m_top = m_rb + 8;
    wr(tmr_pkg::ADDR_CMP_TOP, m_top[7:0]);
    wr(tmr_pkg::ADDR_MAIN_CTRL, 8'h81);
    m_ctc = 1'b1;
    wr(tmr_pkg::ADDR_COUNTER, m_rb[7:0] + 8'h04);
    m_cnt = m_rb + 4;
    run(6);
    state();
    wr(tmr_pkg::ADDR_MAIN_CTRL, 8'h01);
    wr(tmr_pkg::ADDR_GEN_CTRL, 8'h50);
    {m_ctc, m_pwm} = 2'b01;
    wr(tmr_pkg::ADDR_COUNTER, m_top[7:0] - 8'h02);
    m_cnt = m_top - 2;
    repeat (3) @(posedge pclk);
    v = pb.val;
    wr(tmr_pkg::ADDR_GEN_CTRL, 8'h58);
    repeat (3) @(posedge pclk);
    chk("pin_b", {7'h0, v}, {7'h0, pb.val});
    rd(tmr_pkg::ADDR_GEN_CTRL, 8'h50);
    run(4);
    state();
    chk("pwm_b", 8'h01, {7'h0, pb.val});
    chk("inv_oe_b", 8'h01, {7'h0, pb.inv_oe});
    close_out();
  end

  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
